// file: bench/tpwm_tick_gen.sv
/* Prescaler model: one tick every div clocks while run is high.
   Assumes div is 1, 8, 64, 256 or 1024; the bench also changes it while run is high. */
`timescale 1ns/10ps
`default_nettype none
module tpwm_tick_gen (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [10:0] div,
  output logic timer_tick
);
  logic [10:0] cnt_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 11'h000;
      timer_tick <= 1'b0;
    end else if (!run) begin
      cnt_q <= 11'h000;
      timer_tick <= 1'b0;
    end else if (cnt_q >= div - 11'h001) begin
      cnt_q <= 11'h000;
      timer_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 11'h001;
      timer_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: bench/tpwm_top_chk.sv
/* Port checker for the timer waveform generator top.
   Assumes one clock, clk_sys, and sys_rst active high. */
`timescale 1ns/10ps
`default_nettype none
`include "tpwm_map.svh"
module tpwm_top_chk
  import tpwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic timer_tick,
  input wire logic [`TPWM_AW-1:0] reg_addr,
  input wire logic [`TPWM_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`TPWM_DW-1:0] reg_rdata_q,
  input wire logic chan_a_output_pin_q,
  input wire logic chan_a_pin_oe_q,
  input wire logic compare_b_output_pin_q,
  input wire logic compare_b_pin_oe_q,
  input wire logic overflow_flag_q,
  input wire logic capture_flag_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic ctrl_wr;
  logic flag_clr;
  assign ctrl_wr = reg_wr && reg_addr == `TPWM_OFF_CTRL;
  assign flag_clr = reg_wr && reg_addr == `TPWM_OFF_FLAGS
    && reg_wdata[`TPWM_FLAG_OVF];
  // A clear with no tick beside it cannot lose to an event
  sequence s_ovf_clear;
    flag_clr && !timer_tick ##1 !timer_tick;
  endsequence
  a_pin_a_tick: assert property ($changed(chan_a_output_pin_q) |->
    $past(timer_tick, 2) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
    else $error("pin A moved without a tick");
  a_pin_b_tick: assert property ($changed(compare_b_output_pin_q) |->
    $past(timer_tick, 2) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
    else $error("pin B moved without a tick");
  a_ovf_on_tick: assert property ($rose(overflow_flag_q) |->
    $past(timer_tick, 2)) else $error("overflow set without a tick");
  a_capt_on_tick: assert property ($rose(capture_flag_q) |->
    $past(timer_tick, 2)) else $error("capture flag set without a tick");
  a_ovf_sticky: assert property ($fell(overflow_flag_q) |->
    $past(flag_clr, 2)) else $error("overflow fell without a clear");
  a_ovf_clears: assert property (s_ovf_clear |-> ##1 !overflow_flag_q)
    else $error("overflow not cleared");
  a_oe_a_ctrl: assert property ($changed(chan_a_pin_oe_q) |->
    $past(ctrl_wr, 1) || $past(ctrl_wr, 2)) else $error("oe A moved alone");
  a_oe_b_ctrl: assert property ($changed(compare_b_pin_oe_q) |->
    $past(ctrl_wr, 1) || $past(ctrl_wr, 2)) else $error("oe B moved alone");
endmodule
bind tpwm_top tpwm_top_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .timer_tick(timer_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .chan_a_output_pin_q(chan_a_output_pin_q),
  .chan_a_pin_oe_q(chan_a_pin_oe_q),
  .compare_b_output_pin_q(compare_b_output_pin_q),
  .compare_b_pin_oe_q(compare_b_pin_oe_q),
  .overflow_flag_q(overflow_flag_q), .capture_flag_q(capture_flag_q));
`default_nettype wire

// file: bench/tpwm_top_tb.sv
/* Self-checking bench for the timer waveform generator.
   Assumes the prescaler model and the bound port checker. */
`timescale 1ns/10ps
`default_nettype none
`include "tpwm_map.svh"
module tpwm_top_tb
  import tpwm_pkg::*;
;
  logic clk_sys, sys_rst, run, timer_tick, reg_wr, reg_rd, rd_seen;
  logic [10:0] div;
  logic [`TPWM_AW-1:0] reg_addr;
  logic [`TPWM_DW-1:0] reg_wdata, reg_rdata_q, v;
  logic pin_a, oe_a, pin_b, oe_b, ovf, capt;
  logic [15:0] exp_q[$];
  logic [3:0] md[6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
  logic [15:0] msk[6] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h00FF,
    16'h01FF, 16'h03FF};
  logic [31:0] seed = 32'h00007862;
  int num_errors = 0;
  int compares = 0;

  tpwm_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .timer_tick(timer_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .chan_a_output_pin_q(pin_a), .chan_a_pin_oe_q(oe_a),
    .compare_b_output_pin_q(pin_b), .compare_b_pin_oe_q(oe_b),
    .overflow_flag_q(ovf), .capture_flag_q(capt));
  tpwm_tick_gen u_presc (.clk_sys(clk_sys), .sys_rst(sys_rst), .run(run),
    .div(div), .timer_tick(timer_tick));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [15:0] ctl(logic [3:0] m, logic [1:0] a,
    logic [1:0] b, logic [1:0] d);
    return {6'h00, d, b, a, m};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen) check(reg_rdata_q, exp_q.pop_front());
    rd_seen <= reg_rd;
  end

  function automatic logic pin(bit sel);
    return sel ? pin_b : pin_a;
  endfunction

  // Syncs to a second rising edge so stale buffered values have drained
  task automatic measure(input bit sel, input int eh, input int ep);
    int n, h, p;
    n = 0;
    h = 0;
    repeat (2) begin
      while (pin(sel) !== 1'b0 && n < 20000) begin @(posedge clk_sys); n++; end
      while (pin(sel) !== 1'b1 && n < 20000) begin @(posedge clk_sys); n++; end
    end
    while (pin(sel) === 1'b1 && n < 20000) begin @(posedge clk_sys); n++; h++; end
    p = h;
    while (pin(sel) !== 1'b1 && n < 20000) begin @(posedge clk_sys); n++; p++; end
    check(h[15:0], eh[15:0]);
    check(p[15:0], ep[15:0]);
  endtask

  task automatic hold(input bit sel, input logic lvl, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge clk_sys);
      if (pin(sel) !== lvl) bad++;
    end
    check(bad[15:0], 16'h0000);
  endtask

  task automatic setup(input logic [15:0] c, input logic [15:0] a,
    input logic [15:0] b);
    run <= 1'b0;
    repeat (3) @(posedge clk_sys);
    wr(`TPWM_OFF_COUNT, 16'h0000);
    wr(`TPWM_OFF_CTRL, c);
    wr(`TPWM_OFF_CMPA, a);
    wr(`TPWM_OFF_CMPB, b);
    run <= 1'b1;
    @(posedge clk_sys);
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #800000;
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    sys_rst = 1'b1;
    run = 1'b0;
    div = 11'h001;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    rd_seen = 1'b0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(`TPWM_OFF_CTRL, 16'h0000);
    rd(`TPWM_OFF_FLAGS, 16'h0000);
    wr(8'h18, 16'hFFFF);
    rd(8'h18, 16'h0000);
    foreach (md[i]) begin
      wr(`TPWM_OFF_CTRL, ctl(md[i], 2'h2, 2'h2, 2'h0));
      wr(`TPWM_OFF_CMPA, 16'hFFFF);
      rd(`TPWM_OFF_CMPA, msk[i]);
    end
    $display("test reset and masks done");
    setup(ctl(`TPWM_MODE_FP8, 2'h2, 2'h3, 2'h3), 16'h0010, 16'h0080);
    measure(0, 239, 256);
    measure(1, 129, 256);
    check({15'h0000, oe_a}, 16'h0001);
    div <= 11'h008;
    measure(0, 1912, 2048);
    div <= 11'h001;
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      v = {8'h00, seed[7:0] | 8'h01};
      if (v == 16'h00FF) v = 16'h00FE;
      wr(`TPWM_OFF_CMPB, v);
      measure(1, int'(v) + 1, 256);
    end
    wr(`TPWM_OFF_CMPA, 16'h0000);
    measure(0, 255, 256);
    wr(`TPWM_OFF_CMPA, 16'h00FF);
    repeat (600) @(posedge clk_sys);
    hold(0, 1'b1, 600);
    wr(`TPWM_OFF_CAPT, 16'h003F);
    setup(ctl(`TPWM_MODE_FP_CAPT, 2'h2, 2'h2, 2'h3), 16'h0010, 16'h0010);
    measure(0, 47, 64);
    $display("test fast pwm done");
    setup(ctl(`TPWM_MODE_PC8, 2'h2, 2'h3, 2'h3), 16'h0040, 16'h0040);
    measure(0, 128, 510);
    measure(1, 382, 510);
    wr(`TPWM_OFF_CMPA, 16'h0000);
    repeat (1100) @(posedge clk_sys);
    hold(0, 1'b0, 1100);
    // Active A must reach a legal TOP before mode 11 uses it as TOP
    wr(`TPWM_OFF_CMPA, 16'h0003);
    repeat (600) @(posedge clk_sys);
    setup(ctl(`TPWM_MODE_PC_CMPA, 2'h1, 2'h2, 2'h3), 16'h0003, 16'h0002);
    measure(0, 6, 12);
    setup(ctl(`TPWM_MODE_FP_CMPA, 2'h1, 2'h2, 2'h3), 16'h0003, 16'h0002);
    measure(0, 4, 8);
    $display("test dual slope and toggle done");
    run <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check({15'h0000, ovf}, 16'h0001);
    wr(`TPWM_OFF_FLAGS, 16'h000F);
    // Flag output lags the clear by two edges; look once it settles
    @(negedge clk_sys);
    check({15'h0000, ovf}, 16'h0000);
    @(posedge clk_sys);
    rd(`TPWM_OFF_FLAGS, 16'h0000);
    wr(`TPWM_OFF_COUNT, 16'h0002);
    repeat (20) @(posedge clk_sys);
    rd(`TPWM_OFF_COUNT, 16'h0002);
    wr(`TPWM_OFF_CTRL, ctl(`TPWM_MODE_FP8, 2'h2, 2'h2, 2'h0));
    repeat (3) @(posedge clk_sys);
    check({15'h0000, oe_a}, 16'h0000);
    $display("test flags and pins done");
    end_sim();
  end
endmodule
`default_nettype wire

// file: pkg/tpwm_map.svh
/*
  Register offsets, field positions, reset values and TOP constants
  for the 16-bit timer waveform generator.
  Assumes an 8-bit word-per-register address and 16-bit data bus.
*/
`ifndef TPWM_MAP_SVH
`define TPWM_MAP_SVH

`define TPWM_AW 8
`define TPWM_DW 16

`define TPWM_OFF_CTRL 8'h00
`define TPWM_OFF_CMPA 8'h04
`define TPWM_OFF_CMPB 8'h08
`define TPWM_OFF_CAPT 8'h0C
`define TPWM_OFF_COUNT 8'h10
`define TPWM_OFF_FLAGS 8'h14

`define TPWM_CTRL_RESET 16'h0000
`define TPWM_ZERO 16'h0000
`define TPWM_ONE 16'h0001
`define TPWM_MAX 16'hFFFF
`define TPWM_TOP8 16'h00FF
`define TPWM_TOP9 16'h01FF
`define TPWM_TOP10 16'h03FF

`define TPWM_COM_OFF 2'h0
`define TPWM_COM_TOGGLE 2'h1

`define TPWM_MODE_PC8 4'h1
`define TPWM_MODE_PC9 4'h2
`define TPWM_MODE_PC10 4'h3
`define TPWM_MODE_FP8 4'h5
`define TPWM_MODE_FP9 4'h6
`define TPWM_MODE_FP10 4'h7
`define TPWM_MODE_PC_CAPT 4'hA
`define TPWM_MODE_PC_CMPA 4'hB
`define TPWM_MODE_FP_CAPT 4'hE
`define TPWM_MODE_FP_CMPA 4'hF

`define TPWM_FLAG_OVF 0
`define TPWM_FLAG_CMPA 1
`define TPWM_FLAG_CMPB 2
`define TPWM_FLAG_CAPT 3
`define TPWM_FLAG_W 4

`endif

// file: pkg/tpwm_pkg.sv
/*
  Types for the 16-bit timer waveform generator.
  Assumes tpwm_map.svh supplies the numeric constants.
*/
package tpwm_pkg;

  typedef logic [15:0] tpwm_word_t;

  typedef struct packed {
    logic [5:0] unused;
    logic dir_b;
    logic dir_a;
    logic [1:0] com_b;
    logic [1:0] com_a;
    logic [3:0] mode;
  } tpwm_ctrl_s;

  typedef struct packed {
    logic capt;
    logic cmpb;
    logic cmpa;
    logic ovf;
  } tpwm_flags_s;

  typedef enum logic {TPWM_UP, TPWM_DOWN} tpwm_dir_e;

endpackage

// file: rtl/tpwm_channel.sv
/*
  One compare channel: buffered compare value, match detect and the
  waveform flip-flop.
  Assumes tick, count and direction come from the counter in clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tpwm_map.svh"

module tpwm_channel
  import tpwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tick,
  input wire tpwm_word_t count,
  input wire logic going_up,
  input wire logic fast_wrap,
  input wire logic pwm_fast,
  input wire logic pwm_phase,
  input wire logic [1:0] com,
  input wire logic toggle_ok,
  input wire logic wr_en,
  input wire tpwm_word_t wr_data,
  input wire logic load,
  output tpwm_word_t active_q,
  output tpwm_word_t buf_q,
  output logic match,
  output logic wave_q
);

  logic buffered;
  assign buffered = pwm_fast | pwm_phase;

  // Match only counts in timer clock cycles
  assign match = tick & (count == active_q);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      buf_q <= `TPWM_ZERO;
    end else if (wr_en) begin
      buf_q <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      active_q <= `TPWM_ZERO;
    end else if (!buffered && wr_en) begin
      active_q <= wr_data;
    end else if (buffered && load) begin
      active_q <= buf_q;
    end
  end

  // Match beats the wrap so a compare at TOP holds a constant level
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wave_q <= 1'b0;
    end else if (tick) begin
      if (com == `TPWM_COM_TOGGLE && toggle_ok) begin
        if (match) begin
          wave_q <= ~wave_q;
        end
      end else if (com[1] && pwm_fast) begin
        if (match) begin
          wave_q <= ~com[0];
        end else if (fast_wrap) begin
          wave_q <= com[0];
        end
      end else if (com[1] && pwm_phase) begin
        if (match) begin
          wave_q <= going_up ? com[0] : ~com[0];
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/tpwm_top.sv
/*
  16-bit timer waveform generator: fast PWM and phase correct PWM,
  register port, flags and compare pins.
  Assumes timer_tick is a one-cycle enable from a prescaler in clk_sys.
*/
// Overview of operation
// - compare output mode 2 gives non-inverted, 3 inverted phase correct PWM; in fast PWM, 2 is high above the compare value.
// - waveform drives the pin only when its direction bit is set.
// - fast PWM mode 2 sets output on match, opposite level at TOP wrap; mode 3 reversed.
// - fast PWM period is prescale times TOP plus one.
// - fast PWM compare at BOTTOM gives one narrow spike per period.
// - fast PWM compare at TOP gives a constant output level.
// - mode 15 with channel A mode 1 toggles A on each match.
// - modes 1, 2, 3, 10, 11 count up then down.
// - phase correct clears on up-match, sets on down-match; inverting reversed.
// - phase correct TOP is 0xFF, 0x1FF, 0x3FF, capture or A.
// - phase correct reverses at TOP and holds TOP one tick.
// - phase correct sets overflow flag at BOTTOM.
// - A or capture flag set at TOP with the buffer load.
// - phase correct loads compare buffers only at TOP.
// - each channel sets its flag when count equals compare value.
// - fixed TOP masks compare bits above resolution on write.
// - phase correct period is two times prescale times TOP.
// - phase correct compare at BOTTOM or TOP holds output constant.
// - mode 11 with channel A mode 1 toggles A, 50 percent.
// - fast PWM TOP is 0xFF, 0x1FF, 0x3FF, capture or A.
// - fast PWM sets overflow flag when counter reaches TOP.
// - fast PWM channel A write buffered, copied when count clears.
`timescale 1ns/10ps
`default_nettype none
`include "tpwm_map.svh"

module tpwm_top
  import tpwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic timer_tick,
  input wire logic [`TPWM_AW-1:0] reg_addr,
  input wire logic [`TPWM_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`TPWM_DW-1:0] reg_rdata_q,
  output logic chan_a_output_pin_q,
  output logic chan_a_pin_oe_q,
  output logic compare_b_output_pin_q,
  output logic compare_b_pin_oe_q,
  output logic overflow_flag_q,
  output logic capture_flag_q
);

  function automatic logic is_fast(input logic [3:0] m);
    return m == `TPWM_MODE_FP8 || m == `TPWM_MODE_FP9 ||
           m == `TPWM_MODE_FP10 || m == `TPWM_MODE_FP_CAPT ||
           m == `TPWM_MODE_FP_CMPA;
  endfunction

  function automatic logic is_phase(input logic [3:0] m);
    return m == `TPWM_MODE_PC8 || m == `TPWM_MODE_PC9 ||
           m == `TPWM_MODE_PC10 || m == `TPWM_MODE_PC_CAPT ||
           m == `TPWM_MODE_PC_CMPA;
  endfunction

  // Fixed resolution for modes with a constant TOP, else all ones
  function automatic tpwm_word_t fixed_top(input logic [3:0] m);
    case (m)
      `TPWM_MODE_PC8, `TPWM_MODE_FP8: return `TPWM_TOP8;
      `TPWM_MODE_PC9, `TPWM_MODE_FP9: return `TPWM_TOP9;
      `TPWM_MODE_PC10, `TPWM_MODE_FP10: return `TPWM_TOP10;
      default: return `TPWM_MAX;
    endcase
  endfunction

  function automatic logic top_from_capt(input logic [3:0] m);
    return m == `TPWM_MODE_PC_CAPT || m == `TPWM_MODE_FP_CAPT;
  endfunction

  function automatic logic top_from_cmpa(input logic [3:0] m);
    return m == `TPWM_MODE_PC_CMPA || m == `TPWM_MODE_FP_CMPA;
  endfunction

  tpwm_ctrl_s ctrl_q;
  tpwm_flags_s flags_q;
  tpwm_word_t count_q;
  tpwm_word_t capt_q;
  tpwm_dir_e dir_q;

  logic pwm_fast;
  logic pwm_phase;
  tpwm_word_t top;
  tpwm_word_t wr_masked;
  logic at_top;
  logic at_bottom;
  logic going_up;
  logic fast_wrap;
  logic load;
  logic ovf_evt;
  logic top_evt;
  logic wr_ctrl;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_capt;
  logic wr_count;
  logic wr_flags;

  tpwm_word_t active[2];
  tpwm_word_t bufv[2];
  logic match[2];
  logic wave[2];
  logic [1:0] com[2];
  logic toggle_ok[2];
  logic wr_cmp[2];

  assign pwm_fast = is_fast(ctrl_q.mode);
  assign pwm_phase = is_phase(ctrl_q.mode);

  // TOP choice; channel A active value is the double-buffered copy
  always_comb begin
    if (top_from_capt(ctrl_q.mode)) begin
      top = capt_q;
    end else if (top_from_cmpa(ctrl_q.mode)) begin
      top = active[0];
    end else begin
      top = fixed_top(ctrl_q.mode);
    end
  end

  assign wr_masked = reg_wdata & fixed_top(ctrl_q.mode);

  assign at_top = count_q == top;
  assign at_bottom = count_q == `TPWM_ZERO;
  // BOTTOM counts as rising and TOP as falling for dual-slope matches
  assign going_up = at_bottom | (dir_q == TPWM_UP && !at_top);
  assign fast_wrap = pwm_fast & at_top;

  // Buffer load: fast at the clearing cycle, phase correct at TOP
  assign load = timer_tick & at_top &
                (pwm_fast | (pwm_phase && dir_q == TPWM_UP));
  assign top_evt = load;

  always_comb begin
    if (pwm_fast) begin
      ovf_evt = timer_tick & at_top;
    end else if (pwm_phase) begin
      ovf_evt = timer_tick & at_bottom & (dir_q == TPWM_DOWN);
    end else begin
      ovf_evt = timer_tick & (count_q == `TPWM_MAX);
    end
  end

  assign wr_ctrl = reg_wr && reg_addr == `TPWM_OFF_CTRL;
  assign wr_cmpa = reg_wr && reg_addr == `TPWM_OFF_CMPA;
  assign wr_cmpb = reg_wr && reg_addr == `TPWM_OFF_CMPB;
  assign wr_capt = reg_wr && reg_addr == `TPWM_OFF_CAPT;
  assign wr_count = reg_wr && reg_addr == `TPWM_OFF_COUNT;
  assign wr_flags = reg_wr && reg_addr == `TPWM_OFF_FLAGS;

  assign com[0] = ctrl_q.com_a;
  assign com[1] = ctrl_q.com_b;
  assign toggle_ok[0] = top_from_cmpa(ctrl_q.mode);
  assign toggle_ok[1] = 1'b0;
  assign wr_cmp[0] = wr_cmpa;
  assign wr_cmp[1] = wr_cmpb;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      tpwm_channel u_chan (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick(timer_tick),
        .count(count_q),
        .going_up(going_up),
        .fast_wrap(fast_wrap),
        .pwm_fast(pwm_fast),
        .pwm_phase(pwm_phase),
        .com(com[gi]),
        .toggle_ok(toggle_ok[gi]),
        .wr_en(wr_cmp[gi]),
        .wr_data(wr_masked),
        .load(load),
        .active_q(active[gi]),
        .buf_q(bufv[gi]),
        .match(match[gi]),
        .wave_q(wave[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= tpwm_ctrl_s'(`TPWM_CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_q <= tpwm_ctrl_s'(reg_wdata);
    end
  end

  // Capture register is not buffered; a low write may miss TOP
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      capt_q <= `TPWM_ZERO;
    end else if (wr_capt) begin
      capt_q <= reg_wdata;
    end
  end

  // Counter; every step waits for the timer tick
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= `TPWM_ZERO;
      dir_q <= TPWM_UP;
    end else if (wr_count) begin
      count_q <= reg_wdata;
    end else if (timer_tick) begin
      if (pwm_fast) begin
        if (at_top) begin
          count_q <= `TPWM_ZERO;
        end else begin
          count_q <= count_q + `TPWM_ONE;
        end
        dir_q <= TPWM_UP;
      end else if (pwm_phase) begin
        unique case (dir_q)
          TPWM_UP: begin
            if (at_top) begin
              dir_q <= TPWM_DOWN;
              count_q <= count_q - `TPWM_ONE;
            end else begin
              count_q <= count_q + `TPWM_ONE;
            end
          end
          TPWM_DOWN: begin
            if (at_bottom) begin
              dir_q <= TPWM_UP;
              count_q <= count_q + `TPWM_ONE;
            end else begin
              count_q <= count_q - `TPWM_ONE;
            end
          end
        endcase
      end else begin
        count_q <= count_q + `TPWM_ONE;
        dir_q <= TPWM_UP;
      end
    end
  end

  // Sticky flags, write one to clear; a same-cycle event wins
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else begin
      flags_q.ovf <= ovf_evt |
        (flags_q.ovf & ~(wr_flags & reg_wdata[`TPWM_FLAG_OVF]));
      flags_q.cmpa <= match[0] | (top_evt & top_from_cmpa(ctrl_q.mode)) |
        (flags_q.cmpa & ~(wr_flags & reg_wdata[`TPWM_FLAG_CMPA]));
      flags_q.cmpb <= match[1] |
        (flags_q.cmpb & ~(wr_flags & reg_wdata[`TPWM_FLAG_CMPB]));
      flags_q.capt <= (top_evt & top_from_capt(ctrl_q.mode)) |
        (flags_q.capt & ~(wr_flags & reg_wdata[`TPWM_FLAG_CAPT]));
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= `TPWM_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `TPWM_OFF_CTRL: reg_rdata_q <= ctrl_q;
        `TPWM_OFF_CMPA: reg_rdata_q <= bufv[0];
        `TPWM_OFF_CMPB: reg_rdata_q <= bufv[1];
        `TPWM_OFF_CAPT: reg_rdata_q <= capt_q;
        `TPWM_OFF_COUNT: reg_rdata_q <= count_q;
        `TPWM_OFF_FLAGS: reg_rdata_q <= {12'h000, flags_q};
        default: reg_rdata_q <= `TPWM_ZERO;
      endcase
    end else begin
      reg_rdata_q <= `TPWM_ZERO;
    end
  end

  // Pins: one register stage after the waveform flop
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chan_a_output_pin_q <= 1'b0;
      chan_a_pin_oe_q <= 1'b0;
      compare_b_output_pin_q <= 1'b0;
      compare_b_pin_oe_q <= 1'b0;
    end else begin
      chan_a_output_pin_q <= wave[0];
      chan_a_pin_oe_q <= ctrl_q.dir_a &&
                         ctrl_q.com_a != `TPWM_COM_OFF;
      compare_b_output_pin_q <= wave[1];
      compare_b_pin_oe_q <= ctrl_q.dir_b &&
                            ctrl_q.com_b != `TPWM_COM_OFF;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_flag_q <= 1'b0;
      capture_flag_q <= 1'b0;
    end else begin
      overflow_flag_q <= flags_q.ovf;
      capture_flag_q <= flags_q.capt;
    end
  end

endmodule

`default_nettype wire
